// >>> core/mem_mode_defines.svh
// offsets, field positions and constants of the memory mode block
`ifndef MEM_MODE_DEFINES_SVH
`define MEM_MODE_DEFINES_SVH
`define MODE_REG_ADDR 16'hfffc
`define CMD_REG_ADDR 16'hfff0
`define STAT_REG_ADDR 16'hfff4
`define CL_LSB 0
`define BW_BIT 3
`define AG_LSB 4
`define RI_LSB 7
`define WT_LSB 10
`define RCD_LSB 12
`define RAS_LSB 14
`define RP_LSB 17
`define RFC_LSB 19
`define RRD_LSB 23
`define RSV_BIT 26
`define WR_BIT 30
`define MODE_WMASK 32'h41ffffff
`define MODE_RESET 32'h00000000
`define CL3 3'h3
`define CL2 3'h2
`define WT_TWO 2'h2
`define WR_LONG_CLKS 4'h2
`define WR_SHORT_CLKS 4'h1
`define RI_CODE0_CLKS 11'h180
`define RI_CODE7_CLKS 11'h610
`define RI_UNIT 11'h040
`define RAS_MIN 3'h2
`define RFC_MIN 4'h3
`define RFC_MAX 4'ha
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> core/mem_mode_pkg.sv
// types of the memory mode block
package mem_mode_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_act = 3'b001,
    st_cas = 3'b010,
    st_pre = 3'b011,
    st_ref = 3'b100,
    st_wait = 3'b101
  } cmd_state_t;
  typedef struct packed {
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic refr;
  } mem_cmd_t;
  typedef struct packed {
    logic [1:0] bank_bits;
    logic [3:0] row_bits;
    logic [3:0] col_bits;
    logic fcram;
    logic wide_bus;
    logic [1:0] cas_lat;
  } mem_geom_t;
endpackage

// >>> core/mem_mode.sv
// memory mode register, AXI4-Lite slave and command spacing scheduler
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "mem_mode_defines.svh"
// Behaviour
// - cas latency from field: 011 gives three, 010 gives two, others flagged
// - data bus 64 bits when width bit set, else 32 bits
// - address geometry decoded from five legal codes, others flagged
// - refresh every 384, 1552 or 64 times code internal clocks
// - write turnaround: only code 10, two clocks, is legal
// - activate to cas wait of zero to three clocks
// - bank active at least two to seven clocks
// - precharge to activate wait of one to three clocks
// - refresh to activate wait of three to ten clocks
// - activate to activate spacing of two or three clocks
// - write recovery two clocks when bit set, else one
// - bit 26 reads one and writes to it are dropped
// - software reset keeps mode register contents
module mem_mode
  import mem_mode_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic soft_reset, // software reset pulse
  input wire logic [15:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [31:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [15:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [31:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read valid
  input wire logic s_rready, // read ready
  output mem_cmd_t cmd, // memory command, one cycle
  output mem_geom_t geom, // decoded geometry
  output logic mode_bad // illegal code in mode register
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return a[15:2] == r[15:2];
  endfunction

  logic [31:0] mode_reg, mode_next;
  logic mode_set_reg, mode_set_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [15:0] aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0] req_reg, req_next; // act, rd, wr, pre, ref requests
  logic wr_fire;
  logic [4:0] issued;

  assign s_awready = !aw_got_reg && !bvalid_reg;
  assign s_wready = !w_got_reg && !bvalid_reg;
  assign s_arready = !rvalid_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;

  // status: bit0 mode written, bit1 bad code, bit2 scheduler busy
  logic busy;
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    aw_next = aw_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    mode_next = mode_reg;
    mode_set_next = mode_set_reg;
    req_next = req_reg & ~issued; // a write in the same cycle sets again
    wr_fire = 1'b0;
    if (s_awvalid && s_awready) begin
      aw_got_next = 1'b1;
      aw_next = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_got_next = 1'b1;
      wd_next = s_wdata;
      ws_next = s_wstrb;
    end
    if (aw_got_reg && w_got_reg) begin
      wr_fire = 1'b1;
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `RESP_OKAY;
      if (hit(aw_reg, `MODE_REG_ADDR)) begin
        mode_next = merge(mode_reg, wd_reg, ws_reg) & `MODE_WMASK;
        mode_set_next = 1'b1;
      end else if (hit(aw_reg, `CMD_REG_ADDR)) begin
        req_next = req_next | wd_reg[4:0];
      end else if (hit(aw_reg, `STAT_REG_ADDR)) begin
        bresp_next = `RESP_OKAY;
      end else begin
        bresp_next = `RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_bready) bvalid_next = 1'b0;
    if (s_arvalid && s_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `RESP_OKAY;
      if (hit(s_araddr, `MODE_REG_ADDR)) begin
        rdata_next = mode_reg;
        rdata_next[`RSV_BIT] = 1'b1;
      end else if (hit(s_araddr, `CMD_REG_ADDR)) begin
        rdata_next = {27'h0, req_reg};
      end else if (hit(s_araddr, `STAT_REG_ADDR)) begin
        rdata_next = {29'h0, busy, mode_bad, mode_set_reg};
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = `RESP_SLVERR;
      end
    end else if (rvalid_reg && s_rready) begin
      rvalid_next = 1'b0;
    end
    if (soft_reset) req_next = 5'h00;
  end

  // field decode
  logic [2:0] f_cl, f_ag, f_ri, f_ras;
  logic [1:0] f_wt, f_rcd, f_rp, f_rrd;
  logic [3:0] f_rfc;
  logic f_bw, f_wr;
  assign f_cl = mode_reg[`CL_LSB +: 3];
  assign f_bw = mode_reg[`BW_BIT];
  assign f_ag = mode_reg[`AG_LSB +: 3];
  assign f_ri = mode_reg[`RI_LSB +: 3];
  assign f_wt = mode_reg[`WT_LSB +: 2];
  assign f_rcd = mode_reg[`RCD_LSB +: 2];
  assign f_ras = mode_reg[`RAS_LSB +: 3];
  assign f_rp = mode_reg[`RP_LSB +: 2];
  assign f_rfc = mode_reg[`RFC_LSB +: 4];
  assign f_rrd = mode_reg[`RRD_LSB +: 2];
  assign f_wr = mode_reg[`WR_BIT];

  logic cl_bad, ag_bad;
  always_comb begin
    geom = '0;
    geom.wide_bus = f_bw;
    geom.cas_lat = (f_cl == `CL3) ? 2'h3 : 2'h2;
    cl_bad = (f_cl != `CL3) && (f_cl != `CL2);
    ag_bad = 1'b0;
    case (f_ag)
      3'h1: begin geom.bank_bits = 2'h2; geom.row_bits = 4'hd; geom.col_bits = 4'h9; end
      3'h7: begin geom.bank_bits = 2'h2; geom.row_bits = 4'hc; geom.col_bits = 4'h9; end
      3'h6: begin geom.bank_bits = 2'h2; geom.row_bits = 4'hc; geom.col_bits = 4'h8; end
      3'h5: begin geom.bank_bits = 2'h2; geom.row_bits = 4'hb; geom.col_bits = 4'h8; end
      3'h4: begin
        geom.bank_bits = 2'h1;
        geom.row_bits = 4'hb;
        geom.col_bits = 4'h8;
        geom.fcram = 1'b1;
      end
      default: ag_bad = 1'b1;
    endcase
  end
  assign mode_bad = cl_bad || ag_bad || (f_wt != `WT_TWO) || (f_ras < `RAS_MIN) ||
                    (f_rp == 2'h0) || (f_rfc < `RFC_MIN) || (f_rfc > `RFC_MAX) ||
                    (f_rrd < 2'h2);

  // refresh interval
  logic [10:0] ri_clks;
  assign ri_clks = (f_ri == 3'h0) ? `RI_CODE0_CLKS : (f_ri == 3'h7) ? `RI_CODE7_CLKS :
                   11'(`RI_UNIT * f_ri);
  logic [10:0] rcnt_reg, rcnt_next;
  logic ref_due_reg, ref_due_next;

  // scheduler
  cmd_state_t st_reg, st_next;
  logic [3:0] wait_reg, wait_next;
  logic [3:0] ras_reg, ras_next, rrd_reg, rrd_next;
  mem_cmd_t cmd_next, cmd_reg;
  assign cmd = cmd_reg;
  assign busy = (st_reg != st_idle);

  always_comb begin
    st_next = st_reg;
    wait_next = (wait_reg != 4'h0) ? wait_reg - 4'h1 : 4'h0;
    ras_next = (ras_reg != 4'h0) ? ras_reg - 4'h1 : 4'h0;
    rrd_next = (rrd_reg != 4'h0) ? rrd_reg - 4'h1 : 4'h0;
    rcnt_next = rcnt_reg;
    ref_due_next = ref_due_reg;
    cmd_next = '0;
    issued = 5'h00;
    if (mode_set_reg) begin
      if (rcnt_reg + 11'h001 >= ri_clks) begin
        rcnt_next = 11'h000;
        ref_due_next = 1'b1;
      end else begin
        rcnt_next = rcnt_reg + 11'h001;
      end
    end
    if (mode_set_reg && wait_reg == 4'h0) begin
      case (st_reg)
        st_idle: begin
          if (ref_due_reg) begin
            cmd_next.refr = 1'b1;
            ref_due_next = 1'b0;
            wait_next = f_rfc;
            st_next = st_wait;
          end else if (req_reg[4] && rrd_reg == 4'h0) begin
            cmd_next.act = 1'b1;
            issued[4] = 1'b1;
            ras_next = {1'b0, f_ras};
            rrd_next = {2'h0, f_rrd};
            wait_next = {2'h0, f_rcd};
            st_next = st_act;
          end
        end
        st_act: begin
          if (req_reg[3]) begin
            cmd_next.rd = 1'b1;
            issued[3] = 1'b1;
            st_next = st_cas;
          end else if (req_reg[2]) begin
            cmd_next.wr = 1'b1;
            issued[2] = 1'b1;
            wait_next = f_wr ? `WR_LONG_CLKS : `WR_SHORT_CLKS;
            st_next = st_cas;
          end else if (req_reg[1]) begin
            st_next = st_cas;
          end
        end
        st_cas: begin
          if (req_reg[1] && ras_reg == 4'h0) begin
            cmd_next.pre = 1'b1;
            issued[1] = 1'b1;
            wait_next = {2'h0, f_rp};
            st_next = st_wait;
          end else if (req_reg[2]) begin
            cmd_next.wr = 1'b1;
            issued[2] = 1'b1;
            wait_next = {2'h0, f_wt};
          end else if (req_reg[3]) begin
            cmd_next.rd = 1'b1;
            issued[3] = 1'b1;
          end
        end
        default: st_next = st_idle;
      endcase
    end
    if (soft_reset) st_next = st_idle;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `MODE_RESET;
      mode_set_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_reg <= 16'h0000;
      wd_reg <= 32'h00000000;
      ws_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
      req_reg <= 5'h00;
      st_reg <= st_idle;
      wait_reg <= 4'h0;
      ras_reg <= 4'h0;
      rrd_reg <= 4'h0;
      rcnt_reg <= 11'h000;
      ref_due_reg <= 1'b0;
      cmd_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      mode_set_reg <= mode_set_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      req_reg <= req_next;
      st_reg <= st_next;
      wait_reg <= wait_next;
      ras_reg <= ras_next;
      rrd_reg <= rrd_next;
      rcnt_reg <= rcnt_next;
      ref_due_reg <= ref_due_next;
      cmd_reg <= cmd_next;
    end
  end

  no_cmd_early_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_set_reg |-> cmd_reg == '0) else $error("command before mode write");
  rsv_reads_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_arvalid && s_arready && s_araddr == `MODE_REG_ADDR) |=> s_rdata[`RSV_BIT])
    else $error("reserved bit not one");
  rsv_store_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_reg[`RSV_BIT]) else $error("reserved bit stored");
  soft_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (soft_reset && !wr_fire) |=> mode_reg == $past(mode_reg)) else $error("mode lost");
  rcd_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_next.act && f_rcd == 2'h3) |=> (!cmd_next.rd && !cmd_next.wr) [*3])
    else $error("cas too early");
  rfc_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_next.refr && f_rfc == 4'ha) |=> !cmd_next.act [*8]) else $error("act after ref");
  wide_bus_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && hit(aw_reg, `MODE_REG_ADDR) && ws_reg[0]) |=>
    geom.wide_bus == $past(wd_reg[`BW_BIT])) else $error("bus width wrong");
  cl_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (f_cl == `CL2) |-> geom.cas_lat == 2'h2 && !cl_bad) else $error("cas latency wrong");
  geom_fc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (f_ag == 3'h4) |-> geom.fcram && geom.bank_bits == 2'h1) else $error("fcram map");
endmodule

// >>> sim/sdram_far_model.sv
// memory device model that checks command spacing seen at its pins
module sdram_far_model
  import mem_mode_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire mem_cmd_t cmd, // command pulses from the controller
  input wire logic [31:0] mode, // mode word the host programmed
  input wire logic armed, // mode register has been written
  output int errs // spacing violations seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc, t_act, t_pre, t_ref, t_wr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cyc = 0;
      t_act = -100;
      t_pre = -100;
      t_ref = -100;
      t_wr = -100;
      errs = 0;
    end else begin
      cyc++;
      if (cmd != '0 && !armed) errs++;
      if (cmd.act) begin
        if (cyc - t_act < int'(mode[24:23])) errs++;
        if (cyc - t_pre < int'(mode[18:17])) errs++;
        if (cyc - t_ref < int'(mode[22:19])) errs++;
        t_act = cyc;
      end
      if ((cmd.rd || cmd.wr) && cyc - t_act < int'(mode[13:12])) errs++;
      if (cmd.wr) t_wr = cyc;
      if (cmd.pre) begin
        if (cyc - t_act < int'(mode[16:14])) errs++;
        if (cyc - t_wr < (mode[30] ? 2 : 1)) errs++;
        t_pre = cyc;
      end
      if (cmd.refr) t_ref = cyc;
    end
  end
endmodule

// >>> sim/graphics_sdram_mode_timing_tb.sv
// self-checking bench for the memory mode block
`include "mem_mode_defines.svh"
module graphics_sdram_mode_timing_tb
  import mem_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, soft_reset, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready, mode_bad;
  logic [15:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, exp_mode, base, m, rd_d, lf;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic armed;
  logic [13:0] exp_g;
  mem_cmd_t cmd;
  mem_geom_t geom;
  int n_fail, num_checks, errs, cyc, t_ref, gap, n_act, n_rd, n_wr, n_pre;
  int ag[5] = '{1, 7, 6, 5, 4};
  int bk[5] = '{2, 2, 2, 2, 1};
  int rw[5] = '{13, 12, 12, 11, 11};
  int cl[5] = '{9, 9, 8, 8, 8};
  int rc[3] = '{0, 3, 7};
  int ri;

  mem_mode dut_u (.aclk, .aresetn, .soft_reset, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .cmd, .geom, .mode_bad);
  sdram_far_model mem_u (.aclk, .aresetn, .cmd, .mode(exp_mode), .armed, .errs);

  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cmd.refr) begin
      gap = cyc - t_ref;
      t_ref = cyc;
    end
    n_act += cmd.act;
    n_rd += cmd.rd;
    n_wr += cmd.wr;
    n_pre += cmd.pre;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      if (s_awvalid && s_awready) aw_ok = 1;
      if (s_wvalid && s_wready) w_ok = 1;
      @(posedge aclk);
      if (aw_ok) s_awvalid <= 0;
      if (w_ok) s_wvalid <= 0;
    end
    do @(negedge aclk); while (!s_bvalid);
    rsp = s_bresp;
    @(posedge aclk);
    s_bready <= 0;
    if (a == `MODE_REG_ADDR) exp_mode = d;
    if (a == `MODE_REG_ADDR) armed = 1;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    do @(negedge aclk); while (!s_arready);
    @(posedge aclk);
    s_arvalid <= 0;
    do @(negedge aclk); while (!s_rvalid);
    rd_d = s_rdata;
    rsp = s_rresp;
    @(posedge aclk);
    s_rready <= 0;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    stop_test;
  end

  initial begin
    {aresetn, soft_reset, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, exp_mode} = '0;
    s_wstrb = 4'hf;
    armed = 0;
    lf = 32'h75ee;
    base = 32'h4154f893; // legal timings, geometry 001, refresh code 1
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (30) @(posedge aclk);
    rd(`STAT_REG_ADDR);
    chk("status idle", 32'h2, rd_d);
    chk("early cmds", 0, n_act + n_rd + n_wr + n_pre);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      m = lf & 32'hfbffffff;
      wr(`MODE_REG_ADDR, m);
      chk("write resp", `RESP_OKAY, rsp);
      rd(`MODE_REG_ADDR);
      chk("mode readback", (m & `MODE_WMASK) | 32'h04000000, rd_d);
    end
    rd(16'h0100);
    chk("unmapped resp", `RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd_d);
    wr(16'h0100, 32'h0);
    chk("unmapped bresp", `RESP_SLVERR, rsp);
    for (int i = 0; i < 5; i++) begin
      m = {base[31:7], 3'(ag[i]), i[0], i[0] ? `CL2 : `CL3};
      wr(`MODE_REG_ADDR, m);
      exp_g = {2'(bk[i]), 4'(rw[i]), 4'(cl[i]), i == 4, i[0], i[0] ? 2'h2 : 2'h3};
      chk("geom", 32'(exp_g), 32'(geom));
      chk("mode ok", 0, mode_bad);
    end
    foreach (rc[i]) begin
      m = i == 0 ? {base[31:7], 3'h0, base[3:0]} : i == 1 ? {base[31:12], 2'h1, base[9:0]}
          : {base[31:3], 3'h0};
      wr(`MODE_REG_ADDR, m);
      chk("mode bad", 1, mode_bad);
    end
    foreach (rc[i]) begin
      wr(`MODE_REG_ADDR, {base[31:10], 3'(rc[i]), base[6:0]});
      ri = rc[i] == 0 ? 384 : rc[i] == 7 ? 1552 : 64 * rc[i];
      repeat (2 * ri + 30) @(posedge aclk);
      chk("refresh gap", ri, gap);
    end
    wr(`CMD_REG_ADDR, 32'h16);
    repeat (40) @(posedge aclk);
    wr(`CMD_REG_ADDR, 32'h1a);
    repeat (40) @(posedge aclk);
    chk("cmd counts", 32'h02010102, {8'(n_act), 8'(n_rd), 8'(n_wr), 8'(n_pre)});
    @(posedge aclk);
    soft_reset <= 1;
    @(posedge aclk);
    soft_reset <= 0;
    rd(`MODE_REG_ADDR);
    chk("mode after soft reset", (exp_mode & `MODE_WMASK) | 32'h04000000, rd_d);
    rd(`STAT_REG_ADDR);
    chk("status written", 32'h1, rd_d & 32'h3);
    chk("spacing errors", 0, errs);
    stop_test;
  end
endmodule
